// [testbench/pmcg_periph_model.sv]
// Stand-in for one group of peripherals, each running only on its gated clock
`timescale 1ns/1ns
module pmcg_periph_model
(
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	// Clock enables, one per peripheral slot
	input  wire pmcg_pkg::pmcg_word_t run,
	// One flip-flop per slot that flips on every clock it receives
	output      pmcg_pkg::pmcg_word_t moved_r
);
	import pmcg_pkg::*;

	// A slot whose clock is stopped holds its state, so a frozen bit shows a stopped module
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			moved_r <= 16'h0000;
		else
			moved_r <= moved_r ^ run;
	end
endmodule // pmcg_periph_model

// [testbench/tb_peripheral_module_clock_gate.sv]
// Self-checking bench for the peripheral module disable block, small variant
`timescale 1ns/1ns
module tb_peripheral_module_clock_gate;
	import pmcg_pkg::*;

	// ------------------------------------------------------------------
	// Addresses and slot masks
	// ------------------------------------------------------------------
	localparam logic [15:0] A_ONE  = 16'h1DC0;
	localparam logic [15:0] A_TWO  = 16'h1DC8;
	localparam logic [15:0] A_RUN1 = 16'h1DD0;
	localparam logic [15:0] A_RUN2 = 16'h1DD8;
	localparam logic [15:0] A_NONE = 16'h1DC4;
	localparam pmcg_word_t  P_ONE  = 16'h38EB;
	localparam pmcg_word_t  P_TWO  = 16'h0303;

	// Bench signals
	logic        clock;
	logic        rst_n;
	logic [15:0] avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [3:0]  avs_byteenable;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	pmcg_word_t  run_one_r;
	pmcg_word_t  run_two_r;
	pmcg_word_t  sfr_write_one;
	pmcg_word_t  sfr_read_one;
	pmcg_word_t  sfr_write_two;
	pmcg_word_t  sfr_read_two;
	pmcg_word_t  wr_ok_one;
	pmcg_word_t  rd_ok_one;
	pmcg_word_t  wr_ok_two;
	pmcg_word_t  rd_ok_two;
	pmcg_word_t  moved;
	pmcg_word_t  mv;
	int          failures;
	int          n_checks;

	// Small variant, so absent slots are exercised too
	pmcg_top #(.SMALL_VARIANT(1'b1)) dut
	(
		.clock               (clock),
		.rst_n               (rst_n),
		.avs_address         (avs_address),
		.avs_read            (avs_read),
		.avs_write           (avs_write),
		.avs_writedata       (avs_writedata),
		.avs_byteenable      (avs_byteenable),
		.avs_readdata        (avs_readdata),
		.avs_waitrequest     (avs_waitrequest),
		.run_one_r           (run_one_r),
		.run_two_r           (run_two_r),
		.sfr_write_one       (sfr_write_one),
		.sfr_read_one        (sfr_read_one),
		.sfr_write_two       (sfr_write_two),
		.sfr_read_two        (sfr_read_two),
		.sfr_write_ok_one_r  (wr_ok_one),
		.sfr_read_valid_one_r(rd_ok_one),
		.sfr_write_ok_two_r  (wr_ok_two),
		.sfr_read_valid_two_r(rd_ok_two)
	);

	// Peripherals of the first group
	pmcg_periph_model periph
	(
		.clock  (clock),
		.rst_n  (rst_n),
		.run    (run_one_r),
		.moved_r(moved)
	);

	// 100 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #5 clock = ~clock;
	end

	// ------------------------------------------------------------------
	// Compare, verdict and bus tasks
	// ------------------------------------------------------------------
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp)
		begin
			failures++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	task automatic close_out;
		$display("checks %0d, failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	// Bounded wait for the slave's answer; a hung bus ends the run
	task automatic wait_ack;
		for (int i = 0; i < 20; i++)
		begin
			@(posedge clock);
			if (avs_waitrequest === 1'b0)
				return;
		end
		failures++;
		$display("unexpected waitrequest: expected 0, seen 1");
		close_out();
	endtask

	task automatic bus_wr(input logic [15:0] a, input logic [15:0] d, input logic [1:0] be);
		@(posedge clock);
		avs_address <= a;
		avs_writedata <= {16'h0000, d};
		avs_byteenable <= {2'b00, be};
		avs_write <= 1'b1;
		wait_ack();
		avs_write <= 1'b0;
	endtask

	task automatic rd_chk(input string what, input logic [15:0] a, input logic [31:0] exp);
		@(posedge clock);
		avs_address <= a;
		avs_read <= 1'b1;
		wait_ack();
		chk(what, exp, avs_readdata);
		avs_read <= 1'b0;
	endtask

	// One cycle of core strobes, then the qualified strobes against the expected enables
	task automatic guard(input pmcg_word_t w, input pmcg_word_t r, input pmcg_word_t e1,
		input pmcg_word_t e2);
		@(posedge clock);
		sfr_write_one <= w;
		sfr_read_one <= r;
		sfr_write_two <= r;
		sfr_read_two <= w;
		@(posedge clock);
		sfr_write_one <= 16'h0000;
		sfr_read_one <= 16'h0000;
		sfr_write_two <= 16'h0000;
		sfr_read_two <= 16'h0000;
		@(posedge clock);
		chk("write_ok_one", {16'h0000, w & e1}, {16'h0000, wr_ok_one});
		chk("read_valid_one", {16'h0000, r & e1}, {16'h0000, rd_ok_one});
		chk("write_ok_two", {16'h0000, r & e2}, {16'h0000, wr_ok_two});
		chk("read_valid_two", {16'h0000, w & e2}, {16'h0000, rd_ok_two});
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		failures = 0;
		n_checks = 0;
		rst_n = 1'b0;
		avs_address = 16'h0000;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0000_0000;
		avs_byteenable = 4'h0;
		sfr_write_one = 16'h0000;
		sfr_read_one = 16'h0000;
		sfr_write_two = 16'h0000;
		sfr_read_two = 16'h0000;
		repeat (3) @(posedge clock);
		rst_n <= 1'b1;
		chk("run_one", {16'h0000, P_ONE}, {16'h0000, run_one_r});
		chk("run_two", {16'h0000, P_TWO}, {16'h0000, run_two_r});
		rd_chk("disable_one", A_ONE, 32'h0000_0000);
		rd_chk("disable_two", A_TWO, 32'h0000_0000);
		// Back-to-back all-ones writes keep only the implemented slots
		bus_wr(A_ONE, 16'hFFFF, 2'b11);
		bus_wr(A_TWO, 16'hFFFF, 2'b11);
		rd_chk("disable_one", A_ONE, 32'h0000_F9EB);
		rd_chk("disable_two", A_TWO, 32'h0000_C30F);
		rd_chk("run_status_one", A_RUN1, 32'h0000_0000);
		mv = moved;
		repeat (4) @(posedge clock);
		chk("moved", {16'h0000, mv}, {16'h0000, moved});
		// Unmapped place: write dropped, read is zero
		bus_wr(A_NONE, 16'h0000, 2'b11);
		bus_wr(A_RUN1, 16'h0000, 2'b11);
		rd_chk("unmapped", A_NONE, 32'h0000_0000);
		rd_chk("disable_one", A_ONE, 32'h0000_F9EB);
		// Low lane only, then timer1 cleared and set through the high lane
		bus_wr(A_ONE, 16'h0000, 2'b01);
		rd_chk("disable_one", A_ONE, 32'h0000_F900);
		bus_wr(A_ONE, 16'hF100, 2'b10);
		@(posedge clock);
		chk("run_one", 32'h0000_00EB, {16'h0000, run_one_r});
		@(posedge clock);
		chk("run_one", 32'h0000_08EB, {16'h0000, run_one_r});
		bus_wr(A_ONE, 16'hF900, 2'b10);
		@(posedge clock);
		chk("run_one", 32'h0000_08EB, {16'h0000, run_one_r});
		@(posedge clock);
		chk("run_one", 32'h0000_00EB, {16'h0000, run_one_r});
		// Absent slots hold their bits but gate nothing
		bus_wr(A_ONE, 16'hC100, 2'b11);
		bus_wr(A_TWO, 16'hC00C, 2'b11);
		rd_chk("disable_one", A_ONE, 32'h0000_C100);
		rd_chk("disable_two", A_TWO, 32'h0000_C00C);
		rd_chk("run_status_one", A_RUN1, 32'h0000_38EB);
		rd_chk("run_status_two", A_RUN2, 32'h0000_0303);
		mv = moved;
		@(posedge clock);
		chk("moved", {16'h0000, mv ^ P_ONE}, {16'h0000, moved});
		// Access to registers of stopped modules is refused
		bus_wr(A_ONE, 16'h0028, 2'b11);
		bus_wr(A_TWO, 16'h0001, 2'b11);
		repeat (2) @(posedge clock);
		guard(16'hFFFF, 16'h5A5A, 16'h38C3, 16'h0302);
		// Reset in mid-run clears both registers again
		@(posedge clock);
		rst_n <= 1'b0;
		@(posedge clock);
		rst_n <= 1'b1;
		// The enables take their reset value at the edge that saw reset, so look one edge on
		@(posedge clock);
		chk("run_one", {16'h0000, P_ONE}, {16'h0000, run_one_r});
		rd_chk("disable_one", A_ONE, 32'h0000_0000);
		rd_chk("disable_two", A_TWO, 32'h0000_0000);
		close_out();
	end
endmodule // tb_peripheral_module_clock_gate

// [verilog/pmcg_access_guard.sv]
// Blocks register access of peripherals whose clock is stopped
`timescale 1ns/1ns
`include "pmcg_consts.svh"
module pmcg_access_guard
(
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	// Effective enables and raw access strobes
	input  wire pmcg_pkg::pmcg_word_t run,
	input  wire pmcg_pkg::pmcg_word_t sfr_write,
	input  wire pmcg_pkg::pmcg_word_t sfr_read,
	// Qualified strobes
	output      pmcg_pkg::pmcg_word_t write_ok_r,
	output      pmcg_pkg::pmcg_word_t read_valid_r
);
	import pmcg_pkg::*;

	wire pmcg_word_t write_ok_nxt;
	wire pmcg_word_t read_valid_nxt;

	// A stopped module can neither take a write nor give a valid read
	assign write_ok_nxt   = sfr_write & run;
	assign read_valid_nxt = sfr_read & run;

	// Registered so the peripheral sees a clean strobe
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			write_ok_r   <= `PMCG_RST_WORD;
			read_valid_r <= `PMCG_RST_WORD;
		end
		else
		begin
			write_ok_r   <= write_ok_nxt;
			read_valid_r <= read_valid_nxt;
		end
	end

	write_blocked_a: assert property (@(posedge clock) disable iff (!rst_n)
		((sfr_write & ~run) != `PMCG_RST_WORD)
		|=> ((write_ok_r & ~$past(run)) == `PMCG_RST_WORD))
		else $error("write passed to a disabled peripheral");

endmodule // pmcg_access_guard

// [verilog/pmcg_clock_gate.sv]
// Registered clock enables for one group of peripherals
`timescale 1ns/1ns
`include "pmcg_consts.svh"
module pmcg_clock_gate
(
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	// Disable bits and the slots that exist
	input  wire pmcg_pkg::pmcg_word_t disable_bits,
	input  wire pmcg_pkg::pmcg_word_t present,
	// Enables for the clock gating cells
	output      pmcg_pkg::pmcg_word_t run_r
);
	import pmcg_pkg::*;

	wire pmcg_word_t run_nxt;

	// Runs only if the slot exists and its bit is clear
	assign run_nxt = ~disable_bits & present;

	// One register stage gives the one-cycle delay in both directions
	always_ff @(posedge clock)
	begin
		if (!rst_n)
			run_r <= present;     // All present peripherals run after reset
		else
			run_r <= run_nxt;
	end

	stop_on_set_a: assert property (@(posedge clock) disable iff (!rst_n)
		(disable_bits != `PMCG_RST_WORD) |=> ((run_r & $past(disable_bits)) == `PMCG_RST_WORD))
		else $error("disabled peripheral still has its clock enabled");

endmodule // pmcg_clock_gate

// [verilog/pmcg_consts.svh]
// Offsets, field positions, masks and reset values of the module disable block
`ifndef PMCG_CONSTS_SVH
`define PMCG_CONSTS_SVH

// ----------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------
`define PMCG_IDX_ONE       16'h0770
`define PMCG_IDX_TWO       16'h0772
`define PMCG_IDX_RUN_ONE   16'h0774
`define PMCG_IDX_RUN_TWO   16'h0776

// ----------------------------------------------------------------------
// Reset and idle values
// ----------------------------------------------------------------------
`define PMCG_RST_WORD      16'h0000
`define PMCG_RD_ZERO       32'h0000_0000
`define PMCG_HI_ZERO       16'h0000

// ----------------------------------------------------------------------
// Field positions, first disable register
// ----------------------------------------------------------------------
`define PMCG_TIMER5_OFF    15
`define PMCG_TIMER4_OFF    14
`define PMCG_TIMER3_OFF    13
`define PMCG_TIMER2_OFF    12
`define PMCG_TIMER1_OFF    11
`define PMCG_CODEC_OFF     8
`define PMCG_I2C_OFF       7
`define PMCG_UART2_OFF     6
`define PMCG_UART1_OFF     5
`define PMCG_SPI_OFF       3
`define PMCG_CAN_OFF       1
`define PMCG_CONVERTER_OFF 0

// ----------------------------------------------------------------------
// Field positions, second disable register
// ----------------------------------------------------------------------
`define PMCG_CAPTURE8_OFF  15
`define PMCG_CAPTURE7_OFF  14
`define PMCG_CAPTURE2_OFF  9
`define PMCG_CAPTURE1_OFF  8
`define PMCG_COMPARE4_OFF  3
`define PMCG_COMPARE3_OFF  2
`define PMCG_COMPARE2_OFF  1
`define PMCG_COMPARE1_OFF  0

// ----------------------------------------------------------------------
// Masks built from the positions
// ----------------------------------------------------------------------
`define PMCG_B(n) (16'h0001 << (n))
`define PMCG_IMPL_ONE (`PMCG_B(`PMCG_TIMER5_OFF) | `PMCG_B(`PMCG_TIMER4_OFF) | \
	`PMCG_B(`PMCG_TIMER3_OFF) | `PMCG_B(`PMCG_TIMER2_OFF) | `PMCG_B(`PMCG_TIMER1_OFF) | \
	`PMCG_B(`PMCG_CODEC_OFF) | `PMCG_B(`PMCG_I2C_OFF) | `PMCG_B(`PMCG_UART2_OFF) | \
	`PMCG_B(`PMCG_UART1_OFF) | `PMCG_B(`PMCG_SPI_OFF) | `PMCG_B(`PMCG_CAN_OFF) | \
	`PMCG_B(`PMCG_CONVERTER_OFF))
`define PMCG_IMPL_TWO (`PMCG_B(`PMCG_CAPTURE8_OFF) | `PMCG_B(`PMCG_CAPTURE7_OFF) | \
	`PMCG_B(`PMCG_CAPTURE2_OFF) | `PMCG_B(`PMCG_CAPTURE1_OFF) | \
	`PMCG_B(`PMCG_COMPARE4_OFF) | `PMCG_B(`PMCG_COMPARE3_OFF) | \
	`PMCG_B(`PMCG_COMPARE2_OFF) | `PMCG_B(`PMCG_COMPARE1_OFF))
`define PMCG_ABSENT_ONE (`PMCG_B(`PMCG_TIMER5_OFF) | `PMCG_B(`PMCG_TIMER4_OFF) | \
	`PMCG_B(`PMCG_CODEC_OFF))
`define PMCG_ABSENT_TWO (`PMCG_B(`PMCG_CAPTURE8_OFF) | `PMCG_B(`PMCG_CAPTURE7_OFF) | \
	`PMCG_B(`PMCG_COMPARE4_OFF) | `PMCG_B(`PMCG_COMPARE3_OFF))

`endif

// [verilog/pmcg_pkg.sv]
// Types and helpers shared by the module disable block
package pmcg_pkg;

	// One bit per peripheral slot
	typedef logic [15:0] pmcg_word_t;

	// Bus slave states
	typedef enum logic {st_idle, st_ack} pmcg_state_t;

	// Byte address match against a register index
	function automatic logic pmcg_hit(input logic [15:0] addr, input logic [15:0] idx);
		pmcg_hit = (addr == {idx[13:0], 2'b00});
	endfunction

	// Byte-lane merge of a write, unimplemented bits forced low
	function automatic pmcg_word_t pmcg_merge(input pmcg_word_t old, input pmcg_word_t wd,
		input logic [1:0] be, input pmcg_word_t impl);
		pmcg_word_t m;
		m = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
		pmcg_merge = m & impl;
	endfunction

endpackage

// [verilog/pmcg_top.sv]
// Peripheral module disable registers with an Avalon-MM slave
`timescale 1ns/1ns
`include "pmcg_consts.svh"
//
// What this block does
// - Set bit stops all clocks of module
// - Disabled module ignores writes, reads invalid
// - Enabled only if bit clear and present
// - Both disable registers reset to zero
// - Set bit stops module one cycle later
// - Cleared bit restarts module one cycle later
// - First register holds timers, serial, codec, converter
// - Second register holds capture and compare bits
// - Absent-module bits stay read/write, control nothing
//
module pmcg_top
#(
	parameter bit SMALL_VARIANT = 1'b0
)
(
	// Clock and reset
	input  wire logic                 clock,
	input  wire logic                 rst_n,
	// Avalon-MM slave
	input  wire logic [15:0]          avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [31:0]          avs_writedata,
	input  wire logic [3:0]           avs_byteenable,
	output      logic [31:0]          avs_readdata,
	output      logic                 avs_waitrequest,
	// Clock enables for the peripheral gating cells
	output      pmcg_pkg::pmcg_word_t run_one_r,
	output      pmcg_pkg::pmcg_word_t run_two_r,
	// Peripheral register strobes from the core
	input  wire pmcg_pkg::pmcg_word_t sfr_write_one,
	input  wire pmcg_pkg::pmcg_word_t sfr_read_one,
	input  wire pmcg_pkg::pmcg_word_t sfr_write_two,
	input  wire pmcg_pkg::pmcg_word_t sfr_read_two,
	// Qualified strobes to the peripherals
	output      pmcg_pkg::pmcg_word_t sfr_write_ok_one_r,
	output      pmcg_pkg::pmcg_word_t sfr_read_valid_one_r,
	output      pmcg_pkg::pmcg_word_t sfr_write_ok_two_r,
	output      pmcg_pkg::pmcg_word_t sfr_read_valid_two_r
);
	import pmcg_pkg::*;

	// ------------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------------
	pmcg_state_t state_r;
	pmcg_state_t state_nxt;
	logic        waitrequest_r;
	logic [31:0] readdata_r;
	pmcg_word_t  dis_one_r;
	pmcg_word_t  dis_two_r;
	pmcg_word_t  dis_one_nxt;
	pmcg_word_t  dis_two_nxt;

	wire         req;
	wire         hit_one;
	wire         hit_two;
	wire         hit_run_one;
	wire         hit_run_two;
	wire         commit;
	wire         commit_one;
	wire         commit_two;
	wire [15:0]  rd_word;
	wire [1:0]   wr_lanes;
	wire pmcg_word_t present_one;
	wire pmcg_word_t present_two;

	// ------------------------------------------------------------------
	// Variant presence
	// ------------------------------------------------------------------
	// Missing modules keep their bits but never get a clock
	assign present_one = SMALL_VARIANT ? (`PMCG_IMPL_ONE & ~`PMCG_ABSENT_ONE)
		: `PMCG_IMPL_ONE;
	assign present_two = SMALL_VARIANT ? (`PMCG_IMPL_TWO & ~`PMCG_ABSENT_TWO)
		: `PMCG_IMPL_TWO;

	// ------------------------------------------------------------------
	// Address decode
	// ------------------------------------------------------------------
	// Only the low two byte lanes carry register data
	assign req         = avs_read | avs_write;
	assign hit_one     = pmcg_hit(avs_address, `PMCG_IDX_ONE);
	assign hit_two     = pmcg_hit(avs_address, `PMCG_IDX_TWO);
	assign hit_run_one = pmcg_hit(avs_address, `PMCG_IDX_RUN_ONE);
	assign hit_run_two = pmcg_hit(avs_address, `PMCG_IDX_RUN_TWO);
	assign wr_lanes    = avs_byteenable[1:0];

	// A write lands only on the edge where waitrequest is seen low
	assign commit     = (state_r == st_ack) & avs_write;
	assign commit_one = commit & hit_one;
	assign commit_two = commit & hit_two;

	// ------------------------------------------------------------------
	// Read data selection
	// ------------------------------------------------------------------
	// Disable bits read back as written, absent slots included
	// Unmapped addresses read as zero rather than erroring the bus
	assign rd_word = hit_one     ? dis_one_r :
		hit_two     ? dis_two_r :
		hit_run_one ? run_one_r :
		hit_run_two ? run_two_r :
		`PMCG_HI_ZERO;

	// ------------------------------------------------------------------
	// Register write merge
	// ------------------------------------------------------------------
	// Unimplemented positions are masked off on write
	assign dis_one_nxt = commit_one
		? pmcg_merge(dis_one_r, avs_writedata[15:0], wr_lanes, `PMCG_IMPL_ONE)
		: dis_one_r;
	assign dis_two_nxt = commit_two
		? pmcg_merge(dis_two_r, avs_writedata[15:0], wr_lanes, `PMCG_IMPL_TWO)
		: dis_two_r;

	// ------------------------------------------------------------------
	// Slave state machine
	// ------------------------------------------------------------------
	// Fixed one wait cycle: simple, and the bench can count on it
	always_comb
	begin
		case (state_r)
			st_idle:
				state_nxt = req ? st_ack : st_idle;
			st_ack:
				state_nxt = st_idle;
			default:
				state_nxt = st_idle;
		endcase
	end

	// Bus handshake registers
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			state_r       <= st_idle;
			waitrequest_r <= 1'b1;
			readdata_r    <= `PMCG_RD_ZERO;
		end
		else
		begin
			state_r       <= state_nxt;
			waitrequest_r <= (state_nxt != st_ack);
			readdata_r    <= {`PMCG_HI_ZERO, rd_word};
		end
	end

	// Disable registers, cleared by reset
	always_ff @(posedge clock)
	begin
		if (!rst_n)
		begin
			dis_one_r <= `PMCG_RST_WORD;
			dis_two_r <= `PMCG_RST_WORD;
		end
		else
		begin
			dis_one_r <= dis_one_nxt;
			dis_two_r <= dis_two_nxt;
		end
	end

	assign avs_readdata    = readdata_r;
	assign avs_waitrequest = waitrequest_r;

	// ------------------------------------------------------------------
	// Clock enables per register group
	// ------------------------------------------------------------------
	// Enables, not gated clocks: the gating cells sit in each peripheral
	pmcg_clock_gate u_gate_one
	(
		.clock        (clock),
		.rst_n        (rst_n),
		.disable_bits (dis_one_r),
		.present      (present_one),
		.run_r        (run_one_r)
	);

	pmcg_clock_gate u_gate_two
	(
		.clock        (clock),
		.rst_n        (rst_n),
		.disable_bits (dis_two_r),
		.present      (present_two),
		.run_r        (run_two_r)
	);

	// ------------------------------------------------------------------
	// Access guards for peripheral registers
	// ------------------------------------------------------------------
	// Guards use the live enable so they track the clock exactly
	pmcg_access_guard u_guard_one
	(
		.clock        (clock),
		.rst_n        (rst_n),
		.run          (run_one_r),
		.sfr_write    (sfr_write_one),
		.sfr_read     (sfr_read_one),
		.write_ok_r   (sfr_write_ok_one_r),
		.read_valid_r (sfr_read_valid_one_r)
	);

	pmcg_access_guard u_guard_two
	(
		.clock        (clock),
		.rst_n        (rst_n),
		.run          (run_two_r),
		.sfr_write    (sfr_write_two),
		.sfr_read     (sfr_read_two),
		.write_ok_r   (sfr_write_ok_two_r),
		.read_valid_r (sfr_read_valid_two_r)
	);

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_n);

	// Write of a set timer1 bit, then the enable drop two edges on
	sequence set_timer1_s;
		commit_one && wr_lanes[1] && avs_writedata[`PMCG_TIMER1_OFF];
	endsequence

	sequence clear_timer1_s;
		commit_one && wr_lanes[1] && !avs_writedata[`PMCG_TIMER1_OFF];
	endsequence

	sequence set_compare1_s;
		commit_two && wr_lanes[0] && avs_writedata[`PMCG_COMPARE1_OFF];
	endsequence

	property stop_after_set_p;
		set_timer1_s |=> dis_one_r[`PMCG_TIMER1_OFF] ##1 !run_one_r[`PMCG_TIMER1_OFF];
	endproperty

	property resume_after_clear_p;
		clear_timer1_s |=> !dis_one_r[`PMCG_TIMER1_OFF] ##1 run_one_r[`PMCG_TIMER1_OFF];
	endproperty

	set_stops_a: assert property (stop_after_set_p)
		else $error("timer1 enable did not drop one cycle after set");

	clear_resumes_a: assert property (resume_after_clear_p)
		else $error("timer1 enable did not return one cycle after clear");

	compare_stops_a: assert property (set_compare1_s |=> ##1 !run_two_r[`PMCG_COMPARE1_OFF])
		else $error("compare1 enable did not drop after set");

	reset_clear_a: assert property (disable iff (1'b0)
		!rst_n |=> (dis_one_r == `PMCG_RST_WORD) && (dis_two_r == `PMCG_RST_WORD))
		else $error("disable registers not zero after reset");

	unimpl_zero_a: assert property (
		((dis_one_r & ~`PMCG_IMPL_ONE) == `PMCG_RST_WORD)
		&& ((dis_two_r & ~`PMCG_IMPL_TWO) == `PMCG_RST_WORD))
		else $error("unimplemented disable bit holds a one");

	absent_idle_a: assert property (
		SMALL_VARIANT |-> ((run_one_r & `PMCG_ABSENT_ONE) == `PMCG_RST_WORD)
		&& ((run_two_r & `PMCG_ABSENT_TWO) == `PMCG_RST_WORD))
		else $error("absent module received a clock enable");

	readback_a: assert property (
		(state_r == st_ack) && avs_read && hit_one
		|-> (avs_readdata == {`PMCG_HI_ZERO, dis_one_r}))
		else $error("first disable register read back wrong");

	present_run_a: assert property (
		$stable(dis_one_r)
		|-> (run_one_r == (~dis_one_r & present_one)))
		else $error("settled enable disagrees with bits and presence");

	bus_answer_a: assert property (
		(state_r == st_idle) && req |=> !avs_waitrequest ##1 avs_waitrequest)
		else $error("slave did not answer in one wait cycle");

	// Second group, storage and read paths; a stray write must never move a register
	sequence clear_compare1_s;
		commit_two && wr_lanes[0] && !avs_writedata[`PMCG_COMPARE1_OFF];
	endsequence

	sequence status_write_s;
		commit && (hit_run_one || hit_run_two);
	endsequence

	compare_resumes_a: assert property (
		clear_compare1_s |=> ##1 run_two_r[`PMCG_COMPARE1_OFF])
		else $error("compare1 enable did not return after clear");

	readback_two_a: assert property (
		(state_r == st_ack) && avs_read && hit_two
		|-> (avs_readdata == {`PMCG_HI_ZERO, dis_two_r}))
		else $error("second disable register read back wrong");

	write_one_lands_a: assert property (
		commit_one && (wr_lanes == 2'b11)
		|=> (dis_one_r == ($past(avs_writedata[15:0]) & `PMCG_IMPL_ONE)))
		else $error("full write to first disable register did not land");

	write_two_lands_a: assert property (
		commit_two && (wr_lanes == 2'b11)
		|=> (dis_two_r == ($past(avs_writedata[15:0]) & `PMCG_IMPL_TWO)))
		else $error("full write to second disable register did not land");

	status_readonly_a: assert property (
		status_write_s |=> $stable(dis_one_r) && $stable(dis_two_r))
		else $error("write to a status register changed a disable register");

	unmapped_zero_a: assert property (
		(state_r == st_ack) && avs_read
		&& !(hit_one || hit_two || hit_run_one || hit_run_two)
		|-> (avs_readdata == `PMCG_RD_ZERO))
		else $error("unmapped read returned data");

	upper_zero_a: assert property (
		avs_readdata[31:16] == `PMCG_HI_ZERO)
		else $error("upper read data half not zero");

	absent_kept_a: assert property (
		SMALL_VARIANT && commit_one && wr_lanes[1] && avs_writedata[`PMCG_TIMER5_OFF]
		|=> dis_one_r[`PMCG_TIMER5_OFF])
		else $error("absent timer5 bit did not hold a written one");

	read_blocked_a: assert property (
		((sfr_read_one & ~run_one_r) != `PMCG_RST_WORD)
		|=> ((sfr_read_valid_one_r & ~$past(run_one_r)) == `PMCG_RST_WORD))
		else $error("read of a disabled peripheral flagged valid");

	reset_run_a: assert property (disable iff (1'b0)
		!rst_n |=> (run_one_r == present_one) && (run_two_r == present_two))
		else $error("clock enables not at presence mask after reset");

	idle_wait_a: assert property (
		(state_r == st_idle) |-> avs_waitrequest)
		else $error("waitrequest low while slave idle");

	settled_two_a: assert property (
		$stable(dis_two_r) |-> (run_two_r == (~dis_two_r & present_two)))
		else $error("settled second enable disagrees with bits and presence");

endmodule // pmcg_top
